// *** verilog/async_serial_transceiver.sv ***
// Contract
// - Sample tick from 13-bit down-counter at base clock/(setting+1); bit is 8 ticks.
// - Telegram: start, 7 or 8 data, optional parity, one or two stops.
// - Start bit opposite idle level; every stop bit at idle level.
// - Parity bit makes ones count odd or even as configured.
// - After reset stay in standby until enable bit set.
// - Received telegram equal to compare value sets address flag and interrupt.
// - Transmit end clearing busy always pulses interrupt, no flag, no mask; abort by clearing enable gives none.
// - Receive-complete each telegram, break each break, each masked.
// - Break and address set flags; receive flag only if FIFO was empty.
// - Interrupt pulses at most once per telegram.
// - Interrupt flags stay valid until end of next telegram.
// - No address event or flag on frame or parity error.
// - Data write loads shifter, sends start, sets busy; end clears busy, interrupts.
// - Falling edge starts reception; at end push FIFO, interrupt, clear busy.
// - Parity mismatch sets parity error; bad start or stop sets frame error.
// - Break after full telegram of low; then quarter bit high before reception.
// - Back-to-back telegrams without idle gap are received.
// - FIFO holds two telegrams with their status.
// - 2-of-3 majority filter, start on filtered fall, sample on fifth tick.
// - Third telegram lost and overrun set; full at second, empty none.
// - Data read pops entry so its status is replaced by next.
// - Clearing enable aborts transfers and resets internal registers.
module async_serial_transceiver #(
  parameter int FIFO_DEPTH = uart_pkg::FIFO_DEPTH_DEF
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [uart_pkg::ADDR_W-1:0] ADDR_IN,
  input wire logic [uart_pkg::DATA_W-1:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [uart_pkg::DATA_W-1:0] RDATA_OUT,
  input wire logic RX_IN,
  output logic TX_OUT,
  output logic IRQ_OUT
);
  import uart_pkg::*;

  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic enable_reg;
  logic [7:0] rate_low_byte_reg;
  logic [RATE_W-1:0] rate_value_reg;
  logic [3:0] control_status_reg;
  logic [7:0] compare_value_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_flag_reg;
  logic [IRQ_W-1:0] irq_flag_next;
  logic [7:0] rd_next;
  logic [7:0] status_byte;
  logic tx_load;
  logic pop;

  assign tx_load = WR_IN && ADDR_IN == DATA_PORT_OFF && enable_reg;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      enable_reg <= 1'b0;
    end else if (WR_IN && ADDR_IN == ENABLE_OFF) begin
      enable_reg <= WDATA_IN[0];
    end
  end

  // Standby holds configuration at reset; it is loaded after enabling
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rate_low_byte_reg <= 8'h00;
      rate_value_reg <= RATE_RESET;
      control_status_reg <= CTRL_RESET;
      compare_value_reg <= 8'h00;
      irq_mask_reg <= '0;
    end else if (!enable_reg) begin
      rate_low_byte_reg <= 8'h00;
      rate_value_reg <= RATE_RESET;
      control_status_reg <= CTRL_RESET;
      compare_value_reg <= 8'h00;
      irq_mask_reg <= '0;
    end else if (WR_IN) begin
      unique case (ADDR_IN)
        RATE_LOW_OFF: rate_low_byte_reg <= WDATA_IN;
        // Low byte waits in a shadow so the counter never sees half a value
        RATE_HIGH_OFF: rate_value_reg <= {WDATA_IN[4:0], rate_low_byte_reg};
        CTRL_STAT_OFF: control_status_reg <= WDATA_IN[3:0];
        COMPARE_OFF: compare_value_reg <= WDATA_IN;
        IRQ_MASK_OFF: irq_mask_reg <= WDATA_IN[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Sample clock generator
  // ---------------------------------------------------------------
  logic [RATE_W-1:0] baud_cnt_reg;
  logic baud_tick_reg;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      baud_cnt_reg <= RATE_RESET;
      baud_tick_reg <= 1'b0;
    end else if (!enable_reg) begin
      baud_cnt_reg <= RATE_RESET;
      baud_tick_reg <= 1'b0;
    end else if (baud_cnt_reg == RATE_RESET) begin
      baud_cnt_reg <= rate_value_reg;
      baud_tick_reg <= 1'b1;
    end else begin
      baud_cnt_reg <= baud_cnt_reg - 13'h0001;
      baud_tick_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Telegram format helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] frame_len(input logic [3:0] cfg);
    frame_len = FRAME_BASE_LEN + {3'h0, cfg[LEN_BIT]} + {3'h0, cfg[PAR_BIT]}
      + {3'h0, cfg[STPB_BIT]};
  endfunction

  function automatic logic [11:0] build_frame(input logic [7:0] d, input logic [3:0] cfg);
    logic [11:0] f;
    logic [7:0] dm;
    int dl;
    dl = cfg[LEN_BIT] ? 8 : 7;
    dm = cfg[LEN_BIT] ? d : {1'b0, d[6:0]};
    f = LINE_IDLE_FRAME;
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < dl) begin
        f[i+1] = dm[i];
      end
    end
    if (cfg[PAR_BIT]) begin
      f[dl+1] = (^dm) ^ cfg[ODD_BIT];
    end
    build_frame = f;
  endfunction

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  logic [11:0] tx_frame_reg;
  logic [3:0] tx_bits_reg;
  logic [2:0] tx_phase_reg;
  logic tx_active_reg;
  logic tx_done_now;

  assign tx_done_now = tx_active_reg && baud_tick_reg && tx_phase_reg == LAST_PHASE
    && tx_bits_reg == 4'h1;

  // A load while busy restarts the telegram; software is expected to wait
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tx_frame_reg <= LINE_IDLE_FRAME;
      tx_bits_reg <= 4'h0;
      tx_phase_reg <= 3'h0;
      tx_active_reg <= 1'b0;
    end else if (!enable_reg) begin
      tx_frame_reg <= LINE_IDLE_FRAME;
      tx_bits_reg <= 4'h0;
      tx_phase_reg <= 3'h0;
      tx_active_reg <= 1'b0;
    end else if (tx_load) begin
      tx_frame_reg <= build_frame(WDATA_IN, control_status_reg);
      tx_bits_reg <= frame_len(control_status_reg);
      tx_phase_reg <= 3'h0;
      tx_active_reg <= 1'b1;
    end else if (tx_active_reg && baud_tick_reg) begin
      tx_phase_reg <= tx_phase_reg + 3'h1;
      if (tx_phase_reg == LAST_PHASE) begin
        tx_frame_reg <= {1'b1, tx_frame_reg[11:1]};
        tx_bits_reg <= tx_bits_reg - 4'h1;
        if (tx_bits_reg == 4'h1) begin
          tx_active_reg <= 1'b0;
        end
      end
    end
  end

  assign TX_OUT = tx_frame_reg[0];

  // ---------------------------------------------------------------
  // Receive input filter
  // ---------------------------------------------------------------
  logic rx_meta_reg;
  logic rx_sync_reg;
  logic samp_a_reg;
  logic samp_b_reg;
  logic filt_reg;
  logic maj_now;
  logic fall_now;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= RX_IN;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  assign maj_now = (samp_a_reg & samp_b_reg) | (samp_a_reg & rx_sync_reg)
    | (samp_b_reg & rx_sync_reg);
  assign fall_now = baud_tick_reg && filt_reg && !maj_now;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      samp_a_reg <= 1'b1;
      samp_b_reg <= 1'b1;
      filt_reg <= 1'b1;
    end else if (!enable_reg) begin
      samp_a_reg <= 1'b1;
      samp_b_reg <= 1'b1;
      filt_reg <= 1'b1;
    end else if (baud_tick_reg) begin
      samp_b_reg <= samp_a_reg;
      samp_a_reg <= rx_sync_reg;
      filt_reg <= maj_now;
    end
  end

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  rx_state_t rx_state_reg;
  logic [2:0] rx_phase_reg;
  logic [3:0] rx_bits_reg;
  logic [11:0] rx_shift_reg;
  logic rx_any_high_reg;
  logic [6:0] low_cnt_reg;
  logic [1:0] high_cnt_reg;
  logic [3:0] len_now;
  logic sample_now;
  logic last_now;
  logic break_now;
  logic [11:0] rx_word;
  logic [7:0] rx_data;
  logic rx_pe;
  logic rx_fe;
  logic [3:0] par_idx;
  logic [3:0] stop_idx;

  assign len_now = frame_len(control_status_reg);
  assign sample_now = baud_tick_reg && rx_state_reg == RX_FRAME && rx_phase_reg == SAMPLE_POINT;
  assign last_now = sample_now && rx_bits_reg == 4'h1;
  // Break length counts a whole telegram of filtered low samples
  assign break_now = baud_tick_reg && !maj_now && rx_state_reg != RX_BREAK
    && low_cnt_reg == {len_now, 3'h0} - 7'h01;

  always_comb begin
    rx_word = {maj_now, rx_shift_reg[11:1]} >> (4'hc - len_now);
    rx_data = control_status_reg[LEN_BIT] ? rx_word[8:1] : {1'b0, rx_word[7:1]};
    par_idx = control_status_reg[LEN_BIT] ? 4'h9 : 4'h8;
    stop_idx = par_idx + {3'h0, control_status_reg[PAR_BIT]};
    rx_pe = control_status_reg[PAR_BIT]
      && (rx_word[par_idx] != ((^rx_data) ^ control_status_reg[ODD_BIT]));
    rx_fe = rx_word[0] || !rx_word[stop_idx]
      || (control_status_reg[STPB_BIT] && !rx_word[stop_idx+4'h1]);
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rx_state_reg <= RX_IDLE;
      rx_phase_reg <= 3'h0;
      rx_bits_reg <= 4'h0;
      rx_shift_reg <= 12'h000;
      rx_any_high_reg <= 1'b0;
      high_cnt_reg <= 2'h0;
    end else if (!enable_reg) begin
      rx_state_reg <= RX_IDLE;
      rx_phase_reg <= 3'h0;
      rx_bits_reg <= 4'h0;
      rx_shift_reg <= 12'h000;
      rx_any_high_reg <= 1'b0;
      high_cnt_reg <= 2'h0;
    end else if (break_now) begin
      rx_state_reg <= RX_BREAK;
      high_cnt_reg <= 2'h0;
    end else begin
      unique case (rx_state_reg)
        RX_IDLE: begin
          if (fall_now) begin
            rx_state_reg <= RX_FRAME;
            rx_phase_reg <= 3'h1;
            rx_bits_reg <= len_now;
            rx_any_high_reg <= 1'b0;
          end
        end
        RX_FRAME: begin
          if (baud_tick_reg) begin
            rx_phase_reg <= rx_phase_reg + 3'h1;
          end
          if (sample_now) begin
            rx_shift_reg <= {maj_now, rx_shift_reg[11:1]};
            rx_any_high_reg <= rx_any_high_reg | maj_now;
            rx_bits_reg <= rx_bits_reg - 4'h1;
            if (rx_bits_reg == 4'h1) begin
              rx_state_reg <= RX_IDLE;
            end
          end
        end
        RX_BREAK: begin
          if (baud_tick_reg) begin
            high_cnt_reg <= maj_now ? high_cnt_reg + 2'h1 : 2'h0;
            if (maj_now && high_cnt_reg == BREAK_GAP_LAST) begin
              rx_state_reg <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // A break beginning inside a telegram is counted from that telegram's end
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      low_cnt_reg <= 7'h00;
    end else if (!enable_reg || break_now) begin
      low_cnt_reg <= 7'h00;
    end else if (baud_tick_reg && rx_state_reg != RX_BREAK) begin
      if (maj_now || (last_now && rx_any_high_reg)) begin
        low_cnt_reg <= 7'h00;
      end else begin
        low_cnt_reg <= low_cnt_reg + 7'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive FIFO
  // ---------------------------------------------------------------
  logic [7:0] fifo_data [FIFO_DEPTH];
  logic [2:0] fifo_stat [FIFO_DEPTH];
  logic [CNT_W-1:0] fifo_cnt_reg;
  logic [CNT_W-1:0] wr_idx;
  logic overrun_reg;
  logic rx_evt_end;
  logic push;
  logic fifo_full;
  logic fifo_empty;
  logic [7:0] entry_data;
  logic [2:0] entry_stat;

  assign fifo_full = fifo_cnt_reg == CNT_W'(FIFO_DEPTH);
  assign fifo_empty = fifo_cnt_reg == '0;
  assign pop = RD_IN && ADDR_IN == DATA_PORT_OFF && enable_reg && !fifo_empty;
  assign rx_evt_end = last_now || break_now;
  assign push = rx_evt_end && (!fifo_full || pop);
  assign wr_idx = fifo_cnt_reg - CNT_W'(pop);
  assign entry_data = break_now ? 8'h00 : rx_data;
  assign entry_stat = break_now ? 3'h6 : {1'b0, rx_fe, rx_pe};

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      fifo_cnt_reg <= '0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo_data[i] <= 8'h00;
        fifo_stat[i] <= 3'h0;
      end
    end else if (!enable_reg) begin
      // Status is read from the head even when empty, so stale entries must go
      fifo_cnt_reg <= '0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo_data[i] <= 8'h00;
        fifo_stat[i] <= 3'h0;
      end
    end else begin
      fifo_cnt_reg <= fifo_cnt_reg + CNT_W'(push) - CNT_W'(pop);
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        if (push && wr_idx == CNT_W'(i)) begin
          fifo_data[i] <= entry_data;
          fifo_stat[i] <= entry_stat;
        end else if (pop) begin
          fifo_data[i] <= fifo_data[(i+1)%FIFO_DEPTH];
          fifo_stat[i] <= fifo_stat[(i+1)%FIFO_DEPTH];
        end
      end
    end
  end

  // Overrun is sticky until the next data read; a new loss wins
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      overrun_reg <= 1'b0;
    end else if (!enable_reg) begin
      overrun_reg <= 1'b0;
    end else if (rx_evt_end && !push) begin
      overrun_reg <= 1'b1;
    end else if (pop) begin
      overrun_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Events and interrupt
  // ---------------------------------------------------------------
  logic addr_hit;
  logic irq_rx;
  logic irq_reg;

  // Full 8-bit compare: in 7-bit mode the compare MSB must be zero
  assign addr_hit = last_now && !rx_pe && !rx_fe && rx_data == compare_value_reg;

  always_comb begin
    irq_flag_next = '0;
    irq_flag_next[IRQ_BREAK_BIT] = break_now && irq_mask_reg[IRQ_BREAK_BIT];
    irq_flag_next[IRQ_ADDR_BIT] = addr_hit && irq_mask_reg[IRQ_ADDR_BIT];
    irq_flag_next[IRQ_RX_BIT] = last_now && irq_mask_reg[IRQ_RX_BIT] && fifo_empty;
  end

  assign irq_rx = (last_now && irq_mask_reg[IRQ_RX_BIT])
    || (addr_hit && irq_mask_reg[IRQ_ADDR_BIT])
    || (break_now && irq_mask_reg[IRQ_BREAK_BIT]);

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irq_flag_reg <= '0;
    end else if (!enable_reg) begin
      irq_flag_reg <= '0;
    end else if (rx_evt_end) begin
      irq_flag_reg <= irq_flag_next;
    end
  end

  // All events of one telegram land on one edge, so they merge into one pulse
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= enable_reg && (tx_done_now || irq_rx);
    end
  end

  assign IRQ_OUT = irq_reg;

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_comb begin
    status_byte = 8'h00;
    status_byte[TX_ACTIVE_BIT] = tx_active_reg;
    status_byte[FULL_BIT] = fifo_full;
    status_byte[EMPTY_BIT] = fifo_empty;
    status_byte[PARITY_ERR_BIT] = fifo_stat[0][0];
    status_byte[OVERRUN_BIT] = overrun_reg;
    status_byte[FRAME_ERR_BIT] = fifo_stat[0][1];
    status_byte[BREAK_SEEN_BIT] = fifo_stat[0][2];
    status_byte[RX_ACTIVE_BIT] = rx_state_reg == RX_FRAME;
  end

  always_comb begin
    rd_next = 8'h00;
    unique case (ADDR_IN)
      RATE_LOW_OFF: rd_next = rate_value_reg[7:0];
      RATE_HIGH_OFF: rd_next = {3'h0, rate_value_reg[12:8]};
      CTRL_STAT_OFF: rd_next = status_byte;
      DATA_PORT_OFF: rd_next = fifo_empty ? 8'h00 : fifo_data[0];
      COMPARE_OFF: rd_next = compare_value_reg;
      IRQ_FLAG_OFF: rd_next = {5'h00, irq_flag_reg};
      IRQ_MASK_OFF: rd_next = {5'h00, irq_mask_reg};
      ENABLE_OFF: rd_next = {7'h00, enable_reg};
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RDATA_OUT <= 8'h00;
    end else begin
      RDATA_OUT <= RD_IN ? rd_next : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  chk_tx_start_bit: assert property (tx_load |=> tx_active_reg && !TX_OUT)
    else $error("Transmit did not start with a low start bit");
  chk_tx_stop_level: assert property (tx_active_reg && tx_bits_reg == 4'h1 |-> TX_OUT)
    else $error("Stop bit not at idle level");
  chk_tx_done_irq: assert property ($fell(tx_active_reg) && enable_reg |-> IRQ_OUT)
    else $error("Transmit end gave no interrupt pulse");
  chk_irq_cause: assert property (IRQ_OUT |-> $past(tx_done_now || irq_rx))
    else $error("Interrupt pulse without an event");
  chk_rx_single: assert property (irq_rx |=> !irq_rx ##1 !irq_rx)
    else $error("Receive events repeated for one telegram");
  chk_baud_period: assert property (disable iff (!RST_N_IN || rate_value_reg != 13'h0001)
    baud_tick_reg && baud_cnt_reg == 13'h0001 |=> !baud_tick_reg ##1 baud_tick_reg)
    else $error("Sample tick period wrong");
  chk_addr_err: assert property (last_now && (rx_pe || rx_fe)
    |=> !irq_flag_reg[IRQ_ADDR_BIT])
    else $error("Address flag set on bad telegram");
  chk_overrun_set: assert property (rx_evt_end && fifo_full && !pop
    |=> overrun_reg && fifo_full)
    else $error("Overrun not flagged");
  chk_rx_flag_first: assert property (last_now && fifo_empty && irq_mask_reg[IRQ_RX_BIT]
    |=> irq_flag_reg[IRQ_RX_BIT] && !fifo_empty)
    else $error("Receive flag missing for first entry");
  chk_standby_clear: assert property (!enable_reg
    |=> !tx_active_reg && rx_state_reg == RX_IDLE && fifo_empty && !IRQ_OUT)
    else $error("Standby did not clear state");

endmodule // async_serial_transceiver

// *** verilog/uart_pkg.sv ***
package uart_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int RATE_W = 13;
  localparam logic [ADDR_W-1:0] RATE_LOW_OFF = 3'h0;
  localparam logic [ADDR_W-1:0] RATE_HIGH_OFF = 3'h1;
  localparam logic [ADDR_W-1:0] CTRL_STAT_OFF = 3'h2;
  localparam logic [ADDR_W-1:0] DATA_PORT_OFF = 3'h3;
  localparam logic [ADDR_W-1:0] COMPARE_OFF = 3'h4;
  localparam logic [ADDR_W-1:0] IRQ_FLAG_OFF = 3'h5;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFF = 3'h6;
  localparam logic [ADDR_W-1:0] ENABLE_OFF = 3'h7;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int LEN_BIT = 0;
  localparam int PAR_BIT = 1;
  localparam int ODD_BIT = 2;
  localparam int STPB_BIT = 3;
  localparam int TX_ACTIVE_BIT = 0;
  localparam int FULL_BIT = 1;
  localparam int EMPTY_BIT = 2;
  localparam int PARITY_ERR_BIT = 3;
  localparam int OVERRUN_BIT = 4;
  localparam int FRAME_ERR_BIT = 5;
  localparam int BREAK_SEEN_BIT = 6;
  localparam int RX_ACTIVE_BIT = 7;
  localparam int IRQ_BREAK_BIT = 0;
  localparam int IRQ_ADDR_BIT = 1;
  localparam int IRQ_RX_BIT = 2;
  localparam int IRQ_W = 3;

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [RATE_W-1:0] RATE_RESET = 13'h0000;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [11:0] LINE_IDLE_FRAME = 12'hfff;
  localparam logic [3:0] FRAME_BASE_LEN = 4'h9;
  localparam logic [2:0] SAMPLE_POINT = 3'h4;
  localparam logic [2:0] LAST_PHASE = 3'h7;
  localparam logic [1:0] BREAK_GAP_LAST = 2'h1;
  localparam int FIFO_DEPTH_DEF = 2;

  typedef enum logic [1:0] {RX_IDLE, RX_FRAME, RX_BREAK} rx_state_t;

endpackage

// *** verif/remote_serial_peer.sv ***
module remote_serial_peer (
  input wire logic clk_in,
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Remote end at exactly our bit rate
  // ----------------------------------------
  localparam int BIT_CLKS = 16;
  logic [11:0] cap_reg;
  int cap_cnt;
  initial begin
    line_out = 1'b1;
    cap_cnt = 0;
    cap_reg = 12'h000;
  end
  // Bits go out LSB first; the last bit stays on the line, so callers end high
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      line_out <= bits[i];
      repeat (BIT_CLKS) @(posedge clk_in);
    end
  endtask
  // Sampled at falling clock mid-bit, since the sender's bit phase is not aligned
  initial forever begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(negedge clk_in);
    for (int k = 0; k < 12; k++) begin
      cap_reg[k] = line_in;
      repeat (BIT_CLKS) @(negedge clk_in);
    end
    cap_cnt++;
  end
endmodule // remote_serial_peer

// *** verif/async_serial_transceiver_tb.sv ***
module async_serial_transceiver_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import uart_pkg::*;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  logic clk, rst_n, wr, rd, rx, tx, irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  int err_total, cmp_count, irq_n, cyc;
  async_serial_transceiver u_async_serial_transceiver (.CLK_IN(clk), .RST_N_IN(rst_n),
    .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .RX_IN(rx), .TX_OUT(tx), .IRQ_OUT(irq));
  remote_serial_peer u_remote_serial_peer (.clk_in(clk), .line_in(tx), .line_out(rx));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // A one-cycle pulse is counted once per event
  always @(posedge clk) begin
    if (irq === 1'b1) irq_n++;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  task automatic summarize();
    $display("Comparisons %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk({4'h0, rdata & m}, {4'h0, e});
  endtask
  task automatic rx_wait(input int target);
    for (int k = 0; k < 64 && irq_n < target; k++) @(posedge clk);
  endtask
  function automatic logic [11:0] frame(input logic [7:0] d, input logic [3:0] c, input logic f);
    logic [11:0] r;
    int n;
    n = c[LEN_BIT] ? 8 : 7;
    r = 12'hfff;
    r[0] = 1'b0;
    for (int i = 0; i < n; i++) r[i+1] = d[i];
    if (c[PAR_BIT]) r[n+1] = ^(d & {c[LEN_BIT], 7'h7f}) ^ c[ODD_BIT] ^ f;
    return r;
  endfunction
  task automatic t_standby();
    wr_reg(RATE_LOW_OFF, 8'h05);
    wr_reg(RATE_HIGH_OFF, 8'h00);
    rd_reg(RATE_LOW_OFF, 8'h00, 8'hff);
    rd_reg(CTRL_STAT_OFF, 8'h04, 8'hff);
    rd_reg(IRQ_FLAG_OFF, 8'h00, 8'hff);
    chk(12'(tx), 12'h001);
  endtask
  task automatic t_tx();
    int n0;
    int c0;
    logic [7:0] d;
    for (int c = 0; c < 16; c++) begin
      d = 8'h5a ^ 8'(c * 37);
      wr_reg(CTRL_STAT_OFF, 8'(c));
      n0 = irq_n;
      c0 = u_remote_serial_peer.cap_cnt;
      wr_reg(DATA_PORT_OFF, d);
      #1 chk(12'(tx), 12'h000);
      rd_reg(CTRL_STAT_OFF, 8'h05, 8'hff);
      for (int k = 0; k < 400 && irq_n == n0; k++) @(posedge clk);
      rd_reg(CTRL_STAT_OFF, 8'h04, 8'hff);
      for (int k = 0; k < 400 && u_remote_serial_peer.cap_cnt == c0; k++) @(posedge clk);
      chk(u_remote_serial_peer.cap_reg, frame(d, 4'(c), 1'b0));
      chk(12'(irq_n - n0), 12'h001);
    end
  endtask
  task automatic t_rx();
    int n0;
    wr_reg(CTRL_STAT_OFF, 8'h01);
    wr_reg(COMPARE_OFF, 8'h3c);
    n0 = irq_n;
    u_remote_serial_peer.send({4'hf, frame(8'h3c, 4'h1, 1'b0)}, 10);
    rx_wait(n0 + 1);
    rd_reg(IRQ_FLAG_OFF, 8'h06, 8'hff);
    rd_reg(CTRL_STAT_OFF, 8'h00, 8'hff);
    rd_reg(DATA_PORT_OFF, 8'h3c, 8'hff);
    chk(12'(irq_n - n0), 12'h001);
    wr_reg(CTRL_STAT_OFF, 8'h03);
    u_remote_serial_peer.send({4'hf, frame(8'h3c, 4'h3, 1'b1)}, 11);
    rx_wait(n0 + 2);
    rd_reg(IRQ_FLAG_OFF, 8'h04, 8'hff);
    rd_reg(CTRL_STAT_OFF, 8'h08, 8'hff);
    rd_reg(DATA_PORT_OFF, 8'h3c, 8'hff);
    wr_reg(CTRL_STAT_OFF, 8'h01);
    u_remote_serial_peer.send({4'hf, frame(8'h3c, 4'h1, 1'b0) & 12'hdff}, 11);
    rx_wait(n0 + 3);
    rd_reg(IRQ_FLAG_OFF, 8'h04, 8'hff);
    rd_reg(CTRL_STAT_OFF, 8'h20, 8'hff);
    rd_reg(DATA_PORT_OFF, 8'h3c, 8'hff);
  endtask
  task automatic t_fifo();
    int n0;
    n0 = irq_n;
    for (int i = 1; i < 4; i++) begin
      u_remote_serial_peer.send({4'hf, frame(8'(i * 17), 4'h1, 1'b0)}, 10);
    end
    rx_wait(n0 + 3);
    rd_reg(IRQ_FLAG_OFF, 8'h00, 8'hff);
    rd_reg(CTRL_STAT_OFF, 8'h12, 8'hff);
    rd_reg(DATA_PORT_OFF, 8'h11, 8'hff);
    rd_reg(CTRL_STAT_OFF, 8'h00, 8'hff);
    rd_reg(DATA_PORT_OFF, 8'h22, 8'hff);
    rd_reg(CTRL_STAT_OFF, 8'h04, 8'hff);
    chk(12'(irq_n - n0), 12'h003);
  endtask
  task automatic t_break_abort();
    u_remote_serial_peer.send(16'h4000, 15);
    rd_reg(IRQ_FLAG_OFF, 8'h01, 8'h01);
    repeat (16) @(posedge clk);
    wr_reg(DATA_PORT_OFF, 8'h00);
    repeat (20) @(posedge clk);
    wr_reg(ENABLE_OFF, 8'h00);
    @(posedge clk);
    #1 chk(12'(tx), 12'h001);
    t_standby();
  endtask
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_standby();
    wr_reg(ENABLE_OFF, 8'h01);
    wr_reg(RATE_LOW_OFF, 8'h01);
    wr_reg(RATE_HIGH_OFF, 8'h00);
    rd_reg(RATE_LOW_OFF, 8'h01, 8'hff);
    wr_reg(IRQ_MASK_OFF, 8'h07);
    t_tx();
    t_rx();
    t_fifo();
    t_break_abort();
    summarize();
  end
endmodule // async_serial_transceiver_tb
